// ---- src/power_regs_pkg.sv ----
package power_regs_pkg;

   // ------------------------------------------------------------
   // Register map
   // ------------------------------------------------------------
   localparam logic [7:0] POWER_COMMAND_ADDR      = 8'h80;
   localparam logic [7:0] BUCK_CONFIGURATION_ADDR = 8'h81;
   localparam logic [7:0] LOCK_MASK_ADDR          = 8'h83;

   // ------------------------------------------------------------
   // Reset values
   // ------------------------------------------------------------
   localparam logic [7:0] POWER_COMMAND_RESET      = 8'h00;
   localparam logic [7:0] BUCK_CONFIGURATION_RESET = 8'h00;
   localparam logic [7:0] LOCK_MASK_RESET          = 8'h00;
   localparam logic [7:0] UNMAPPED_READ_VALUE      = 8'h00;
   localparam logic [7:0] COMMAND_CLEARED          = 8'h00;

   // ------------------------------------------------------------
   // Buck configuration fields
   // ------------------------------------------------------------
   localparam int BUCK_TWO_DCM_BIT     = 7;
   localparam int BUCK_ONE_DCM_BIT     = 6;
   localparam int BUCK_THREE_VALLEY_BIT = 5;
   localparam int BUCK_TWO_VALLEY_BIT  = 4;
   localparam int BUCK_ONE_VALLEY_BIT  = 3;
   localparam int BUCK_THREE_LOWBW_BIT = 2;
   localparam int BUCK_TWO_LOWBW_BIT   = 1;
   localparam int BUCK_ONE_LOWBW_BIT   = 0;

   // ------------------------------------------------------------
   // Lock mask fields
   // ------------------------------------------------------------
   localparam int LINEAR_TWO_LOCK_BIT  = 7;
   localparam int LINEAR_ONE_LOCK_BIT  = 6;
   localparam int BUCKBOOST_LOCK_BIT   = 5;
   localparam int BOOST_LOCK_BIT       = 4;
   localparam int BUCK_THREE_LOCK_BIT  = 3;
   localparam int BUCK_TWO_LOCK_BIT    = 2;
   localparam int BUCK_ONE_LOCK_BIT    = 1;
   localparam int CHARGER_LOCK_BIT     = 0;

   // ------------------------------------------------------------
   // Command codes and seal permission
   // ------------------------------------------------------------
   localparam logic [7:0] HARD_RESET_COMMAND    = 8'hc3;
   localparam logic [7:0] SOFT_RESET_COMMAND    = 8'hd4;
   localparam logic [7:0] SEAL_MODE_COMMAND     = 8'he5;
   localparam logic [7:0] BOOT_RECOVERY_COMMAND = 8'hf6;
   localparam logic [3:0] SEAL_SETTING_FIRST    = 4'hb;
   localparam logic [3:0] SEAL_SETTING_SECOND   = 4'hc;

   // ------------------------------------------------------------
   // Command register sequencing
   // ------------------------------------------------------------
   typedef enum logic [1:0]
   {
      cmd_idle  = 2'b01,
      cmd_check = 2'b10
   } cmd_state_type;

endpackage : power_regs_pkg

// ---- src/power_command_decoder.sv ----
`timescale 1ns/1ps

module power_command_decoder
(
   // Clock and reset
   input  wire logic       sys_clk,
   input  wire logic       rst_n,
   // Code under validation
   input  wire logic       check,
   input  wire logic [7:0] code,
   input  wire logic [3:0] reset_behaviour_setting,
   // Command pulses
   output logic            hard_reset_req,
   output logic            soft_reset_req,
   output logic            seal_mode_req,
   output logic            boot_recovery_req,
   output logic            command_ignored
);

   // ------------------------------------------------------------
   // Code decode
   // ------------------------------------------------------------
   logic hard_reset_req_ff;
   logic soft_reset_req_ff;
   logic seal_mode_req_ff;
   logic boot_recovery_req_ff;
   logic command_ignored_ff;

   wire is_hard   = code == power_regs_pkg::HARD_RESET_COMMAND;
   wire is_soft   = code == power_regs_pkg::SOFT_RESET_COMMAND;
   wire is_seal   = code == power_regs_pkg::SEAL_MODE_COMMAND;
   wire is_boot   = code == power_regs_pkg::BOOT_RECOVERY_COMMAND;
   wire seal_ok   = (reset_behaviour_setting ==
                     power_regs_pkg::SEAL_SETTING_FIRST) |
                    (reset_behaviour_setting ==
                     power_regs_pkg::SEAL_SETTING_SECOND);
   wire seal_go   = is_seal & seal_ok;
   wire code_ok   = is_hard | is_soft | seal_go | is_boot;

   wire nxt_hard_reset_req    = check & is_hard;
   wire nxt_soft_reset_req    = check & is_soft;
   wire nxt_seal_mode_req     = check & seal_go;
   wire nxt_boot_recovery_req = check & is_boot;
   wire nxt_command_ignored   = check & ~code_ok;

   // ------------------------------------------------------------
   // Pulse registers
   // ------------------------------------------------------------
   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         hard_reset_req_ff    <= 1'b0;
         soft_reset_req_ff    <= 1'b0;
         seal_mode_req_ff     <= 1'b0;
         boot_recovery_req_ff <= 1'b0;
         command_ignored_ff   <= 1'b0;
      end
      else
      begin
         hard_reset_req_ff    <= nxt_hard_reset_req;
         soft_reset_req_ff    <= nxt_soft_reset_req;
         seal_mode_req_ff     <= nxt_seal_mode_req;
         boot_recovery_req_ff <= nxt_boot_recovery_req;
         command_ignored_ff   <= nxt_command_ignored;
      end
   end

   assign hard_reset_req    = hard_reset_req_ff;
   assign soft_reset_req    = soft_reset_req_ff;
   assign seal_mode_req     = seal_mode_req_ff;
   assign boot_recovery_req = boot_recovery_req_ff;
   assign command_ignored   = command_ignored_ff;

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   a_seal_gated: assert property (@(posedge sys_clk) disable iff (!rst_n)
      check && is_seal && !seal_ok |=> !seal_mode_req && command_ignored)
      else $error("seal command accepted under a barred setting");

   a_unknown_ignored: assert property (@(posedge sys_clk)
      disable iff (!rst_n)
      check && !is_hard && !is_soft && !is_seal && !is_boot |=>
      command_ignored && !hard_reset_req && !soft_reset_req &&
      !boot_recovery_req)
      else $error("unknown code was not ignored");

endmodule : power_command_decoder

// ---- src/power_cmd_buck_cfg_lock_regs.sv ----
`timescale 1ns/1ps

// What this block does
// - Buck config bit 7 set forces discontinuous mode on buck two.
// - Buck config bit 6 set forces discontinuous mode on buck one.
// - Bit 5 picks buck three valley current: clear low, set high.
// - Bit 4 picks buck two valley current: clear low, set high.
// - Bit 3 picks buck one valley current: clear low, set high.
// - Bit 2 set puts buck three in low bandwidth mode.
// - Bit 1 set puts buck two in low bandwidth mode.
// - Bit 0 set puts buck one in low bandwidth mode.
// - Lock mask bit 6 set excludes linear regulator one from locking.
// - Lock mask bits 5..0 exclude buckboost, boost, bucks, charger.

module power_cmd_buck_cfg_lock_regs
(
   // Clock and reset
   input  wire logic       sys_clk,
   input  wire logic       rst_n,
   // Register port
   input  wire logic [7:0] reg_addr,
   input  wire logic       reg_wr_en,
   input  wire logic       reg_rd_en,
   input  wire logic [7:0] reg_wdata,
   output logic      [7:0] reg_rdata,
   output logic            reg_rvalid,
   // Reset configuration
   input  wire logic [3:0] reset_behaviour_setting,
   // Power commands
   output logic            hard_reset_req,
   output logic            soft_reset_req,
   output logic            seal_mode_req,
   output logic            boot_recovery_req,
   output logic            command_ignored,
   // Buck controls
   output logic            buck_two_forced_discontinuous,
   output logic            buck_one_forced_discontinuous,
   output logic            buck_three_scaling_valley_current,
   output logic            buck_two_scaling_valley_current,
   output logic            buck_one_scaling_valley_current,
   output logic            buck_three_low_bandwidth,
   output logic            buck_two_low_bandwidth,
   output logic            buck_one_low_bandwidth,
   // Lock exclusions
   output logic            linear_two_lock_exclude,
   output logic            linear_one_lock_exclude,
   output logic            buckboost_lock_exclude,
   output logic            boost_lock_exclude,
   output logic            buck_three_lock_exclude,
   output logic            buck_two_lock_exclude,
   output logic            buck_one_lock_exclude,
   output logic            charger_lock_exclude
);

   // ------------------------------------------------------------
   // Storage
   // ------------------------------------------------------------
   logic [7:0]                    power_command_ff;
   logic [7:0]                    buck_configuration_ff;
   logic [7:0]                    lock_mask_ff;
   logic [7:0]                    reg_rdata_ff;
   logic                          reg_rvalid_ff;
   power_regs_pkg::cmd_state_type cmd_state_ff;
   power_regs_pkg::cmd_state_type nxt_cmd_state;
   logic [7:0]                    nxt_power_command;

   // ------------------------------------------------------------
   // Address decode
   // ------------------------------------------------------------
   wire sel_command = reg_addr == power_regs_pkg::POWER_COMMAND_ADDR;
   wire sel_buck    = reg_addr == power_regs_pkg::BUCK_CONFIGURATION_ADDR;
   wire sel_lock    = reg_addr == power_regs_pkg::LOCK_MASK_ADDR;
   wire wr_command  = reg_wr_en & sel_command;
   wire wr_buck     = reg_wr_en & sel_buck;
   wire wr_lock     = reg_wr_en & sel_lock;
   wire checking    = cmd_state_ff == power_regs_pkg::cmd_check;

   wire [7:0] nxt_buck_configuration =
      wr_buck ? reg_wdata : buck_configuration_ff;
   wire [7:0] nxt_lock_mask =
      wr_lock ? reg_wdata : lock_mask_ff;

   // ------------------------------------------------------------
   // Read selection
   // ------------------------------------------------------------
   wire [7:0] nxt_reg_rdata =
      !reg_rd_en  ? reg_rdata_ff          :
      sel_command ? power_command_ff      :
      sel_buck    ? buck_configuration_ff :
      sel_lock    ? lock_mask_ff          :
                    power_regs_pkg::UNMAPPED_READ_VALUE;

   // ------------------------------------------------------------
   // Command register sequencing
   // ------------------------------------------------------------
   always_comb
   begin
      nxt_cmd_state     = cmd_state_ff;
      nxt_power_command = power_command_ff;
      case (cmd_state_ff)
         power_regs_pkg::cmd_idle:
         begin
            if (wr_command)
            begin
               nxt_power_command = reg_wdata;
               nxt_cmd_state     = power_regs_pkg::cmd_check;
            end
         end
         power_regs_pkg::cmd_check:
         begin
            if (wr_command)
            begin
               // A fresh write wins over the self clear
               nxt_power_command = reg_wdata;
               nxt_cmd_state     = power_regs_pkg::cmd_check;
            end
            else
            begin
               nxt_power_command = power_regs_pkg::COMMAND_CLEARED;
               nxt_cmd_state     = power_regs_pkg::cmd_idle;
            end
         end
         default:
         begin
            nxt_power_command = power_regs_pkg::COMMAND_CLEARED;
            nxt_cmd_state     = power_regs_pkg::cmd_idle;
         end
      endcase
   end

   // ------------------------------------------------------------
   // Registers
   // ------------------------------------------------------------
   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         power_command_ff      <= power_regs_pkg::POWER_COMMAND_RESET;
         buck_configuration_ff <= power_regs_pkg::BUCK_CONFIGURATION_RESET;
         lock_mask_ff          <= power_regs_pkg::LOCK_MASK_RESET;
         cmd_state_ff          <= power_regs_pkg::cmd_idle;
      end
      else
      begin
         power_command_ff      <= nxt_power_command;
         buck_configuration_ff <= nxt_buck_configuration;
         lock_mask_ff          <= nxt_lock_mask;
         cmd_state_ff          <= nxt_cmd_state;
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         reg_rdata_ff  <= power_regs_pkg::UNMAPPED_READ_VALUE;
         reg_rvalid_ff <= 1'b0;
      end
      else
      begin
         reg_rdata_ff  <= nxt_reg_rdata;
         reg_rvalid_ff <= reg_rd_en;
      end
   end

   // ------------------------------------------------------------
   // Command validation
   // ------------------------------------------------------------
   power_command_decoder u_decoder
   (
      .sys_clk                 (sys_clk),
      .rst_n                   (rst_n),
      .check                   (checking),
      .code                    (power_command_ff),
      .reset_behaviour_setting (reset_behaviour_setting),
      .hard_reset_req          (hard_reset_req),
      .soft_reset_req          (soft_reset_req),
      .seal_mode_req           (seal_mode_req),
      .boot_recovery_req       (boot_recovery_req),
      .command_ignored         (command_ignored)
   );

   // ------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------
   assign reg_rdata  = reg_rdata_ff;
   assign reg_rvalid = reg_rvalid_ff;

   assign buck_two_forced_discontinuous =
      buck_configuration_ff[power_regs_pkg::BUCK_TWO_DCM_BIT];
   assign buck_one_forced_discontinuous =
      buck_configuration_ff[power_regs_pkg::BUCK_ONE_DCM_BIT];
   assign buck_three_scaling_valley_current =
      buck_configuration_ff[power_regs_pkg::BUCK_THREE_VALLEY_BIT];
   assign buck_two_scaling_valley_current =
      buck_configuration_ff[power_regs_pkg::BUCK_TWO_VALLEY_BIT];
   assign buck_one_scaling_valley_current =
      buck_configuration_ff[power_regs_pkg::BUCK_ONE_VALLEY_BIT];
   assign buck_three_low_bandwidth =
      buck_configuration_ff[power_regs_pkg::BUCK_THREE_LOWBW_BIT];
   assign buck_two_low_bandwidth =
      buck_configuration_ff[power_regs_pkg::BUCK_TWO_LOWBW_BIT];
   assign buck_one_low_bandwidth =
      buck_configuration_ff[power_regs_pkg::BUCK_ONE_LOWBW_BIT];

   assign linear_two_lock_exclude =
      lock_mask_ff[power_regs_pkg::LINEAR_TWO_LOCK_BIT];
   assign linear_one_lock_exclude =
      lock_mask_ff[power_regs_pkg::LINEAR_ONE_LOCK_BIT];
   assign buckboost_lock_exclude =
      lock_mask_ff[power_regs_pkg::BUCKBOOST_LOCK_BIT];
   assign boost_lock_exclude =
      lock_mask_ff[power_regs_pkg::BOOST_LOCK_BIT];
   assign buck_three_lock_exclude =
      lock_mask_ff[power_regs_pkg::BUCK_THREE_LOCK_BIT];
   assign buck_two_lock_exclude =
      lock_mask_ff[power_regs_pkg::BUCK_TWO_LOCK_BIT];
   assign buck_one_lock_exclude =
      lock_mask_ff[power_regs_pkg::BUCK_ONE_LOCK_BIT];
   assign charger_lock_exclude =
      lock_mask_ff[power_regs_pkg::CHARGER_LOCK_BIT];

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_n);

   a_buck_two_dcm: assert property (
      reg_wr_en && sel_buck |=>
      buck_two_forced_discontinuous == $past(reg_wdata[7]))
      else $error("buck two discontinuous bit not taken");

   a_buck_one_dcm: assert property (
      reg_wr_en && sel_buck |=>
      buck_one_forced_discontinuous == $past(reg_wdata[6]))
      else $error("buck one discontinuous bit not taken");

   a_valley_select: assert property (
      reg_wr_en && sel_buck |=>
      buck_three_scaling_valley_current == $past(reg_wdata[5]) &&
      buck_two_scaling_valley_current == $past(reg_wdata[4]))
      else $error("valley current bits not taken");

   a_buck_one_valley: assert property (
      reg_wr_en && sel_buck |=>
      buck_one_scaling_valley_current == $past(reg_wdata[3]))
      else $error("buck one valley bit not taken");

   a_low_bw_three: assert property (
      reg_wr_en && sel_buck ##1 !(reg_wr_en && sel_buck) |=>
      buck_three_low_bandwidth == $past(reg_wdata[2], 2))
      else $error("buck three bandwidth bit not held");

   a_low_bw_pair: assert property (
      reg_wr_en && sel_buck |=>
      {buck_two_low_bandwidth, buck_one_low_bandwidth} ==
      $past(reg_wdata[1:0]))
      else $error("buck bandwidth bits not taken");

   a_linear_excl: assert property (
      reg_wr_en && sel_lock |=>
      linear_two_lock_exclude == $past(reg_wdata[7]) &&
      linear_one_lock_exclude == $past(reg_wdata[6]))
      else $error("linear lock exclusion bits not taken");

   a_group_excl: assert property (
      reg_wr_en && sel_lock |=>
      {buckboost_lock_exclude, boost_lock_exclude,
       buck_three_lock_exclude, buck_two_lock_exclude,
       buck_one_lock_exclude, charger_lock_exclude} ==
      $past(reg_wdata[5:0]))
      else $error("group lock exclusion bits not taken");

   a_cmd_selfclear: assert property (
      reg_wr_en && sel_command ##1 !(reg_wr_en && sel_command) |=>
      power_command_ff == power_regs_pkg::COMMAND_CLEARED)
      else $error("command register did not clear itself");

   a_hard_reset_fires: assert property (
      reg_wr_en && sel_command &&
      reg_wdata == power_regs_pkg::HARD_RESET_COMMAND
      ##1 !(reg_wr_en && sel_command) |=>
      hard_reset_req ##1 !hard_reset_req)
      else $error("hard reset pulse missing or too long");

   a_seal_permitted: assert property (
      reg_wr_en && sel_command &&
      reg_wdata == power_regs_pkg::SEAL_MODE_COMMAND &&
      (reset_behaviour_setting == power_regs_pkg::SEAL_SETTING_FIRST ||
       reset_behaviour_setting == power_regs_pkg::SEAL_SETTING_SECOND)
      ##1 $stable(reset_behaviour_setting) |=> seal_mode_req)
      else $error("permitted seal command not issued");

   c_soft_reset: cover property (soft_reset_req);
   c_boot_recovery: cover property (boot_recovery_req);
   c_ignored_code: cover property (command_ignored);
   c_back_to_back: cover property (wr_command && checking);

endmodule : power_cmd_buck_cfg_lock_regs

// ---- verification/tb_top.sv ----
`timescale 1ns/1ps

module tb_top;

   // ------------------------------------------------------------
   // Stimulus and observed signals
   // ------------------------------------------------------------
   logic       sys_clk                 = 1'b0;
   logic       rst_n                   = 1'b0;
   logic [7:0] reg_addr                = 8'h00;
   logic       reg_wr_en               = 1'b0;
   logic       reg_rd_en               = 1'b0;
   logic [7:0] reg_wdata               = 8'h00;
   logic [3:0] reset_behaviour_setting = 4'h0;
   logic [7:0] reg_rdata;
   logic       reg_rvalid;
   logic       hard_reset_req, soft_reset_req, seal_mode_req;
   logic       boot_recovery_req, command_ignored;
   logic       b2_dcm, b1_dcm, b3_val, b2_val, b1_val, b3_bw, b2_bw, b1_bw;
   logic       l2_ex, l1_ex, bb_ex, bst_ex, k3_ex, k2_ex, k1_ex, chg_ex;
   int         failures                = 0;
   int         cmp_count               = 0;
   wire  [7:0] buck_bits = {b2_dcm, b1_dcm, b3_val, b2_val, b1_val,
                            b3_bw, b2_bw, b1_bw};
   wire  [7:0] lock_bits = {l2_ex, l1_ex, bb_ex, bst_ex, k3_ex, k2_ex,
                            k1_ex, chg_ex};
   wire  [4:0] pulses    = {hard_reset_req, soft_reset_req, seal_mode_req,
                            boot_recovery_req, command_ignored};

   power_cmd_buck_cfg_lock_regs dut
   (
      .sys_clk(sys_clk), .rst_n(rst_n), .reg_addr(reg_addr),
      .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en), .reg_wdata(reg_wdata),
      .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
      .reset_behaviour_setting(reset_behaviour_setting),
      .hard_reset_req(hard_reset_req), .soft_reset_req(soft_reset_req),
      .seal_mode_req(seal_mode_req), .boot_recovery_req(boot_recovery_req),
      .command_ignored(command_ignored),
      .buck_two_forced_discontinuous(b2_dcm),
      .buck_one_forced_discontinuous(b1_dcm),
      .buck_three_scaling_valley_current(b3_val),
      .buck_two_scaling_valley_current(b2_val),
      .buck_one_scaling_valley_current(b1_val),
      .buck_three_low_bandwidth(b3_bw), .buck_two_low_bandwidth(b2_bw),
      .buck_one_low_bandwidth(b1_bw),
      .linear_two_lock_exclude(l2_ex), .linear_one_lock_exclude(l1_ex),
      .buckboost_lock_exclude(bb_ex), .boost_lock_exclude(bst_ex),
      .buck_three_lock_exclude(k3_ex), .buck_two_lock_exclude(k2_ex),
      .buck_one_lock_exclude(k1_ex), .charger_lock_exclude(chg_ex)
   );

   always #25 sys_clk = ~sys_clk;

   // ------------------------------------------------------------
   // Compare, bus and closing tasks
   // ------------------------------------------------------------
   task chk_byte(input logic [7:0] got, input logic [7:0] exp);
      cmp_count++;
      if (got !== exp)
      begin
         failures++;
         $display("BAD t=%0t got %h exp %h", $time, got, exp);
      end
   endtask : chk_byte

   task chk_pulse(input logic [4:0] got, input logic [4:0] exp);
      cmp_count++;
      if (got !== exp)
      begin
         failures++;
         $display("BAD t=%0t got %h exp %h", $time, got, exp);
      end
   endtask : chk_pulse

   task close_out;
      $display("Counts: %0d compares, %0d mismatches", cmp_count, failures);
      if (failures == 0 && cmp_count > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : close_out

   task reg_write(input logic [7:0] a, input logic [7:0] d);
      @(negedge sys_clk);
      reg_wr_en = 1'b1;
      reg_addr  = a;
      reg_wdata = d;
      @(negedge sys_clk);
      reg_wr_en = 1'b0;
   endtask : reg_write

   task read_chk(input logic [7:0] a, input logic [7:0] exp);
      int i;
      @(negedge sys_clk);
      reg_rd_en = 1'b1;
      reg_addr  = a;
      @(negedge sys_clk);
      reg_rd_en = 1'b0;
      i = 0;
      while (reg_rvalid !== 1'b1 && i < 4)
      begin
         @(negedge sys_clk);
         i++;
      end
      if (i == 4)
      begin
         failures++;
         close_out();
      end
      chk_byte(reg_rdata, exp);
   endtask : read_chk

   task cmd_run(input logic [7:0] code, input logic [4:0] exp);
      reg_write(8'h80, code);
      @(negedge sys_clk);
      chk_pulse(pulses, exp);
      @(negedge sys_clk);
      chk_pulse(pulses, 5'h00);
      read_chk(8'h80, 8'h00);
   endtask : cmd_run

   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   task test_reset;
      read_chk(8'h81, 8'h00);
      read_chk(8'h83, 8'h00);
      read_chk(8'h80, 8'h00);
      chk_byte(buck_bits, 8'h00);
      chk_byte(lock_bits, 8'h00);
      chk_pulse(pulses, 5'h00);
      $display("test_reset done");
   endtask : test_reset

   task test_buck;
      reg_write(8'h81, 8'ha5);
      chk_byte(buck_bits, 8'ha5);
      reg_write(8'h81, 8'h5a);
      chk_byte(buck_bits, 8'h5a);
      read_chk(8'h81, 8'h5a);
      chk_byte(lock_bits, 8'h00);
      $display("test_buck done");
   endtask : test_buck

   task test_lock;
      reg_write(8'h83, 8'h5a);
      chk_byte(lock_bits, 8'h5a);
      reg_write(8'h83, 8'ha5);
      chk_byte(lock_bits, 8'ha5);
      read_chk(8'h83, 8'ha5);
      chk_byte(buck_bits, 8'h5a);
      $display("test_lock done");
   endtask : test_lock

   task test_unmapped;
      reg_write(8'h82, 8'hff);
      read_chk(8'h82, 8'h00);
      read_chk(8'h81, 8'h5a);
      read_chk(8'h83, 8'ha5);
      $display("test_unmapped done");
   endtask : test_unmapped

   task test_commands;
      reset_behaviour_setting = 4'hb;
      cmd_run(8'hc3, 5'h10);
      cmd_run(8'hd4, 5'h08);
      cmd_run(8'he5, 5'h04);
      cmd_run(8'hf6, 5'h02);
      cmd_run(8'h12, 5'h01);
      cmd_run(8'hc4, 5'h01);
      $display("test_commands done");
   endtask : test_commands

   task test_seal;
      reset_behaviour_setting = 4'h0;
      cmd_run(8'he5, 5'h01);
      reset_behaviour_setting = 4'ha;
      cmd_run(8'he5, 5'h01);
      reset_behaviour_setting = 4'hc;
      cmd_run(8'he5, 5'h04);
      reset_behaviour_setting = 4'hd;
      cmd_run(8'he5, 5'h01);
      $display("test_seal done");
   endtask : test_seal

   task test_back_to_back;
      @(negedge sys_clk);
      reg_wr_en = 1'b1;
      reg_addr  = 8'h80;
      reg_wdata = 8'hc3;
      @(negedge sys_clk);
      reg_wdata = 8'hd4;
      @(negedge sys_clk);
      reg_wr_en = 1'b0;
      chk_pulse(pulses, 5'h10);
      @(negedge sys_clk);
      chk_pulse(pulses, 5'h08);
      @(negedge sys_clk);
      chk_pulse(pulses, 5'h00);
      $display("test_back_to_back done");
   endtask : test_back_to_back

   task test_mid_reset;
      @(negedge sys_clk);
      rst_n = 1'b0;
      @(negedge sys_clk);
      chk_byte(buck_bits, 8'h00);
      chk_byte(lock_bits, 8'h00);
      chk_pulse(pulses, 5'h00);
      @(negedge sys_clk);
      rst_n = 1'b1;
      read_chk(8'h81, 8'h00);
      read_chk(8'h83, 8'h00);
      cmd_run(8'hc3, 5'h10);
      $display("test_mid_reset done");
   endtask : test_mid_reset

   initial
   begin
      #1000000;
      failures++;
      close_out();
   end

   initial
   begin
      repeat (3) @(negedge sys_clk);
      rst_n = 1'b1;
      test_reset();
      test_buck();
      test_lock();
      test_unmapped();
      test_commands();
      test_seal();
      test_back_to_back();
      test_mid_reset();
      close_out();
   end

endmodule : tb_top
